/* src/vic_pkg.sv */
// package: register map, field positions and reset values of the interrupt command block
`default_nettype none
package vic_pkg;
    localparam int unsigned VIC_NSRC = 32;
    localparam int unsigned VIC_AW = 8;
    localparam int unsigned VIC_IDW = 5;
    // byte offsets of the 32-bit registers on the register bus
    localparam logic [VIC_AW-1:0] VIC_OFF_IVEC = 8'h00;
    localparam logic [VIC_AW-1:0] VIC_OFF_FVEC = 8'h04;
    localparam logic [VIC_AW-1:0] VIC_OFF_PEND = 8'h08;
    localparam logic [VIC_AW-1:0] VIC_OFF_MASK = 8'h0C;
    localparam logic [VIC_AW-1:0] VIC_OFF_CORE = 8'h10;
    localparam logic [VIC_AW-1:0] VIC_OFF_ENA = 8'h14;
    localparam logic [VIC_AW-1:0] VIC_OFF_DIS = 8'h18;
    localparam logic [VIC_AW-1:0] VIC_OFF_CLR = 8'h1C;
    localparam logic [VIC_AW-1:0] VIC_OFF_SET = 8'h20;
    localparam logic [VIC_AW-1:0] VIC_OFF_EOS = 8'h24;
    localparam logic [VIC_AW-1:0] VIC_OFF_SPUR = 8'h28;
    localparam logic [VIC_AW-1:0] VIC_OFF_DBG = 8'h2C;
    // source bit positions
    localparam int unsigned VIC_FAST_SOURCE_BIT = 0;
    localparam int unsigned VIC_SYSTEM_SOURCE_BIT = 1;
    // core line status and debug control fields
    localparam int unsigned VIC_FAST_LINE_STATUS = 0;
    localparam int unsigned VIC_NORMAL_LINE_STATUS = 1;
    localparam int unsigned VIC_PROTECTION_ENABLE = 0;
    localparam int unsigned VIC_GLOBAL_LINE_MASK = 1;
    localparam logic [1:0] VIC_DBG_BITS = 2'h3;
    // reset values
    localparam logic [31:0] VIC_RST_WORD = 32'h0000_0000;
    localparam logic [VIC_NSRC-1:0] VIC_RST_SRC = 32'h0000_0000;
    localparam logic [1:0] VIC_RST_DBG = 2'h0;
    localparam logic [VIC_IDW-1:0] VIC_RST_ID = 5'h00;
    // value returned by the fast vector read while a fast interrupt is pending and enabled (arbitrary)
    localparam logic [31:0] VIC_FAST_VEC_DEFAULT = 32'h0000_0000;
    // core-facing line states
    localparam logic VIC_LINE_ACTIVE_N = 1'b0;
    localparam logic VIC_LINE_IDLE_N = 1'b1;
endpackage : vic_pkg
`default_nettype wire

/* src/vic_src_sync.sv */
// source input synchroniser with per-bit rising edge detection
`default_nettype none
module vic_src_sync
    import vic_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // raw sources from outside the clock domain
    input wire logic [VIC_NSRC-1:0] src_i,
    // synchronised rising edges, one-cycle pulses
    output logic [VIC_NSRC-1:0] rise_o
);
    logic [VIC_NSRC-1:0] meta_ff;
    logic [VIC_NSRC-1:0] sync_ff;
    logic [VIC_NSRC-1:0] prev_ff;

    genvar g;
    generate
        for (g = 0; g < VIC_NSRC; g++) begin : g_bit
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    meta_ff[g] <= 1'b0;
                    sync_ff[g] <= 1'b0;
                    prev_ff[g] <= 1'b0;
                end else begin
                    meta_ff[g] <= src_i[g];
                    sync_ff[g] <= meta_ff[g];
                    prev_ff[g] <= sync_ff[g];
                end
            end
            assign rise_o[g] = sync_ff[g] & ~prev_ff[g];
        end
    endgenerate
endmodule : vic_src_sync
`default_nettype wire

/* src/vic_cmd_status.sv */
// command and status registers of the vectored interrupt controller, Wishbone slave
`default_nettype none
module vic_cmd_status
    import vic_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [VIC_AW-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // interrupt sources, rising edge sensitive
    input wire logic [VIC_NSRC-1:0] src_i,
    // request lines to the core, active low
    output logic fast_request_line_n_o,
    output logic normal_request_line_n_o,
    // protection mode state
    output logic protection_enable_o
);
    logic ack_ff;
    logic [31:0] dat_ff;
    logic [VIC_NSRC-1:0] pend_ff;
    logic [VIC_NSRC-1:0] mask_ff;
    logic [31:0] spur_ff;
    logic [1:0] dbg_ff;
    logic cur_valid_ff;
    logic [VIC_IDW-1:0] cur_id_ff;
    logic fast_n_ff;
    logic norm_n_ff;
    logic [VIC_NSRC-1:0] rise;
    logic acc;
    logic wr;
    logic rd;
    logic [31:0] wmask;
    logic [VIC_NSRC-1:0] active;
    logic norm_req;
    logic fast_req;
    logic [VIC_IDW-1:0] top_id;
    logic take_norm;
    logic take_fast;
    logic [VIC_NSRC-1:0] ack_clr;
    logic [VIC_NSRC-1:0] nxt_pend;
    logic [31:0] nxt_dat;

    // byte-lane merge for read-write stores
    function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0] sel);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return r;
    endfunction

    // lowest-numbered set bit among the normal sources
    function automatic logic [VIC_IDW-1:0] first_normal(input logic [VIC_NSRC-1:0] v);
        logic [VIC_IDW-1:0] r;
        r = VIC_RST_ID;
        for (int i = VIC_NSRC - 1; i > VIC_FAST_SOURCE_BIT; i--) begin
            if (v[i]) begin
                r = VIC_IDW'(i);
            end
        end
        return r;
    endfunction

    vic_src_sync u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .src_i(src_i),
        .rise_o(rise)
    );

    assign acc = wb_cyc_i & wb_stb_i & ~ack_ff;
    assign wr = acc & wb_we_i;
    assign rd = acc & ~wb_we_i;
    assign wmask = lane_merge(VIC_RST_WORD, wb_dat_i, wb_sel_i);

    // evaluation of the request lines from the registered pending and mask
    assign active = pend_ff & mask_ff;
    assign fast_req = active[VIC_FAST_SOURCE_BIT];
    assign norm_req = (|active[VIC_NSRC-1:VIC_SYSTEM_SOURCE_BIT]) & ~cur_valid_ff;
    assign top_id = first_normal(active);

    // vector read acknowledges; with protection on only a write to it does
    always_comb begin
        if (dbg_ff[VIC_PROTECTION_ENABLE]) begin
            take_norm = wr && wb_adr_i == VIC_OFF_IVEC && norm_req;
            take_fast = wr && wb_adr_i == VIC_OFF_FVEC && fast_req;
        end else begin
            take_norm = rd && wb_adr_i == VIC_OFF_IVEC && norm_req;
            take_fast = rd && wb_adr_i == VIC_OFF_FVEC && fast_req;
        end
        ack_clr = VIC_RST_SRC;
        if (take_norm) begin
            ack_clr[top_id] = 1'b1;
        end
        if (take_fast) begin
            ack_clr[VIC_FAST_SOURCE_BIT] = 1'b1;
        end
    end

    // bus handshake: ack one cycle after the strobe, dropped the cycle after
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= acc;
        end
    end

    // pending: edges and set commands win over clears in the same cycle
    always_comb begin
        nxt_pend = pend_ff;
        if (wr && wb_adr_i == VIC_OFF_CLR) begin
            nxt_pend = nxt_pend & ~wmask;
        end
        nxt_pend = nxt_pend & ~ack_clr;
        nxt_pend = nxt_pend | rise;
        if (wr && wb_adr_i == VIC_OFF_SET) begin
            nxt_pend = nxt_pend | wmask;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pend_ff <= VIC_RST_SRC;
        end else begin
            pend_ff <= nxt_pend;
        end
    end

    // mask set and clear commands
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mask_ff <= VIC_RST_SRC;
        end else if (wr && wb_adr_i == VIC_OFF_ENA) begin
            mask_ff <= mask_ff | wmask;
        end else if (wr && wb_adr_i == VIC_OFF_DIS) begin
            mask_ff <= mask_ff & ~wmask;
        end
    end

    // spurious vector and debug control stores
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            spur_ff <= VIC_RST_WORD;
            dbg_ff <= VIC_RST_DBG;
        end else if (wr && wb_adr_i == VIC_OFF_SPUR) begin
            spur_ff <= lane_merge(spur_ff, wb_dat_i, wb_sel_i);
        end else if (wr && wb_adr_i == VIC_OFF_DBG && wb_sel_i[0]) begin
            dbg_ff <= wb_dat_i[1:0] & VIC_DBG_BITS;
        end
    end

    // current normal interrupt: captured on acknowledge, ended by end-of-service write
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cur_valid_ff <= 1'b0;
            cur_id_ff <= VIC_RST_ID;
        end else if (wr && wb_adr_i == VIC_OFF_EOS) begin
            cur_valid_ff <= 1'b0;
        end else if (take_norm) begin
            cur_valid_ff <= 1'b1;
            cur_id_ff <= top_id;
        end
    end

    // request lines, held idle under the global line mask
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fast_n_ff <= VIC_LINE_IDLE_N;
            norm_n_ff <= VIC_LINE_IDLE_N;
        end else if (dbg_ff[VIC_GLOBAL_LINE_MASK]) begin
            fast_n_ff <= VIC_LINE_IDLE_N;
            norm_n_ff <= VIC_LINE_IDLE_N;
        end else begin
            fast_n_ff <= fast_req ? VIC_LINE_ACTIVE_N : VIC_LINE_IDLE_N;
            norm_n_ff <= norm_req ? VIC_LINE_ACTIVE_N : VIC_LINE_IDLE_N;
        end
    end

    // read data mux, unmapped offsets read zero
    always_comb begin
        nxt_dat = VIC_RST_WORD;
        case (wb_adr_i)
            VIC_OFF_IVEC: begin
                nxt_dat = norm_req ? 32'(top_id) : spur_ff;
            end
            VIC_OFF_FVEC: begin
                nxt_dat = fast_req ? VIC_FAST_VEC_DEFAULT : spur_ff;
            end
            VIC_OFF_PEND: begin
                nxt_dat = pend_ff;
            end
            VIC_OFF_MASK: begin
                nxt_dat = mask_ff;
            end
            VIC_OFF_CORE: begin
                nxt_dat[VIC_FAST_LINE_STATUS] = ~fast_n_ff;
                nxt_dat[VIC_NORMAL_LINE_STATUS] = ~norm_n_ff;
            end
            VIC_OFF_SPUR: begin
                nxt_dat = spur_ff;
            end
            VIC_OFF_DBG: begin
                nxt_dat[1:0] = dbg_ff;
            end
            default: begin
                nxt_dat = VIC_RST_WORD;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_ff <= VIC_RST_WORD;
        end else if (rd) begin
            dat_ff <= nxt_dat;
        end
    end

    assign wb_ack_o = ack_ff;
    assign wb_dat_o = dat_ff;
    assign fast_request_line_n_o = fast_n_ff;
    assign normal_request_line_n_o = norm_n_ff;
    assign protection_enable_o = dbg_ff[VIC_PROTECTION_ENABLE];

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    pend_read_a: assert property (
        rd && wb_adr_i == VIC_OFF_PEND |=> wb_ack_o && wb_dat_o == $past(pend_ff))
        else $error("pending read mismatch");
    mask_read_a: assert property (
        rd && wb_adr_i == VIC_OFF_MASK |=> wb_dat_o == $past(mask_ff))
        else $error("mask read mismatch");
    fast_stat_a: assert property (
        rd && wb_adr_i == VIC_OFF_CORE
        |=> wb_dat_o[VIC_FAST_LINE_STATUS] == ~$past(fast_n_ff))
        else $error("fast line status mismatch");
    norm_stat_a: assert property (
        rd && wb_adr_i == VIC_OFF_CORE
        |=> wb_dat_o[VIC_NORMAL_LINE_STATUS] == ~$past(norm_n_ff))
        else $error("normal line status mismatch");
    mask_enable_a: assert property (
        wr && wb_adr_i == VIC_OFF_ENA |=> (mask_ff & $past(wmask)) == $past(wmask))
        else $error("enable command lost");
    enable_zero_a: assert property (
        wr && wb_adr_i == VIC_OFF_ENA
        |=> (mask_ff & ~$past(wmask)) == ($past(mask_ff) & ~$past(wmask)))
        else $error("enable command touched other sources");
    mask_disable_a: assert property (
        wr && wb_adr_i == VIC_OFF_DIS |=> (mask_ff & $past(wmask)) == VIC_RST_SRC)
        else $error("disable command lost");
    disable_zero_a: assert property (
        wr && wb_adr_i == VIC_OFF_DIS
        |=> (mask_ff | $past(wmask)) == ($past(mask_ff) | $past(wmask)))
        else $error("disable command touched other sources");
    pend_set_a: assert property (
        wr && wb_adr_i == VIC_OFF_SET |=> (pend_ff & $past(wmask)) == $past(wmask))
        else $error("set command lost");
    set_zero_a: assert property (
        wr && wb_adr_i == VIC_OFF_SET
        |=> ((pend_ff ^ $past(pend_ff | rise)) & ~$past(wmask)) == VIC_RST_SRC)
        else $error("set command touched other sources");
    pend_clear_a: assert property (
        wr && wb_adr_i == VIC_OFF_CLR && rise == VIC_RST_SRC
        |=> (pend_ff & $past(wmask)) == VIC_RST_SRC)
        else $error("clear command lost");
    clear_zero_a: assert property (
        wr && wb_adr_i == VIC_OFF_CLR
        |=> ((pend_ff ^ $past(pend_ff | rise)) & ~$past(wmask)) == VIC_RST_SRC)
        else $error("clear command touched other sources");
    eos_end_a: assert property (
        wr && wb_adr_i == VIC_OFF_EOS |=> !cur_valid_ff)
        else $error("end of service ignored");
    svc_capture_a: assert property (
        take_norm |=> cur_valid_ff && cur_id_ff == $past(top_id))
        else $error("acknowledged source not held in service");
    gmask_idle_a: assert property (
        dbg_ff[VIC_GLOBAL_LINE_MASK] |=> fast_request_line_n_o && normal_request_line_n_o)
        else $error("lines active under global mask");
    protection_enable_read_a: assert property (
        dbg_ff[VIC_PROTECTION_ENABLE] && rd && rise == VIC_RST_SRC
        && (wb_adr_i == VIC_OFF_IVEC || wb_adr_i == VIC_OFF_FVEC)
        |=> pend_ff == $past(pend_ff))
        else $error("vector read acknowledged under protection");
    spur_vec_a: assert property (
        rd && wb_adr_i == VIC_OFF_FVEC && !fast_req |=> wb_dat_o == $past(spur_ff))
        else $error("spurious fast vector wrong");
    ivec_spur_a: assert property (
        rd && wb_adr_i == VIC_OFF_IVEC && !norm_req |=> wb_dat_o == $past(spur_ff))
        else $error("spurious normal vector wrong");
    spur_store_a: assert property (
        wr && wb_adr_i == VIC_OFF_SPUR && wb_sel_i == 4'hF |=> spur_ff == $past(wb_dat_i))
        else $error("spurious vector store lost");
    dbg_store_a: assert property (
        wr && wb_adr_i == VIC_OFF_DBG && wb_sel_i[0] |=> dbg_ff == $past(wb_dat_i[1:0]))
        else $error("debug control store lost");
    line_follow_a: assert property (
        !dbg_ff[VIC_GLOBAL_LINE_MASK] && fast_req ##1 !dbg_ff[VIC_GLOBAL_LINE_MASK]
        |-> !fast_request_line_n_o)
        else $error("fast line did not follow pending");
    norm_follow_a: assert property (
        !dbg_ff[VIC_GLOBAL_LINE_MASK] && norm_req ##1 !dbg_ff[VIC_GLOBAL_LINE_MASK]
        |-> !normal_request_line_n_o)
        else $error("normal line did not follow pending");
    fast_idle_a: assert property (
        !fast_req |=> fast_request_line_n_o)
        else $error("fast line active without request");
    norm_idle_a: assert property (
        !norm_req |=> normal_request_line_n_o)
        else $error("normal line active without request");
    ack_answer_a: assert property (acc |=> wb_ack_o)
        else $error("access not acknowledged");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");

    norm_taken_c: cover property (take_norm ##[1:20] (wr && wb_adr_i == VIC_OFF_EOS));
    fast_line_c: cover property (!fast_request_line_n_o);
    spur_read_c: cover property (rd && wb_adr_i == VIC_OFF_IVEC && !norm_req);
    protection_enable_take_c: cover property (dbg_ff[VIC_PROTECTION_ENABLE] && take_norm);
    fast_take_c: cover property (take_fast);
endmodule : vic_cmd_status
`default_nettype wire

/* bench/vic_core_model.sv */
// core side model: watches both active-low request lines
`default_nettype none
module vic_core_model
    import vic_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // request lines from the controller
    input wire logic fast_request_line_n_i,
    input wire logic normal_request_line_n_i,
    // sticky flags: line was seen active
    output logic fast_seen_o,
    output logic normal_seen_o
);
    timeunit 1ns;
    timeprecision 1ps;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fast_seen_o <= 1'b0;
            normal_seen_o <= 1'b0;
        end else begin
            if (fast_request_line_n_i == VIC_LINE_ACTIVE_N) fast_seen_o <= 1'b1;
            if (normal_request_line_n_i == VIC_LINE_ACTIVE_N) normal_seen_o <= 1'b1;
        end
    end
endmodule // vic_core_model
`default_nettype wire

/* bench/testbench.sv */
// self-checking testbench of the interrupt command and status block
`default_nettype none
module testbench
    import vic_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [VIC_AW-1:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0000_0000, rdat;
    logic ack, fast_n, norm_n, protection_enable, fast_seen, norm_seen;
    logic [VIC_NSRC-1:0] src = 32'h0000_0000;
    int bad_count = 0;
    int comparisons = 0;
    int cycles = 0;

    always #4 clk_i = ~clk_i;

    vic_cmd_status dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .src_i(src), .fast_request_line_n_o(fast_n),
        .normal_request_line_n_o(norm_n), .protection_enable_o(protection_enable));

    vic_core_model core (.clk_i(clk_i), .rst_i(rst_i), .fast_request_line_n_i(fast_n),
        .normal_request_line_n_i(norm_n), .fast_seen_o(fast_seen), .normal_seen_o(norm_seen));

    task automatic results();
        if (bad_count == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            bad_count = bad_count + 1;
            results();
        end
    end

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    // one classic cycle: hold everything until ack is sampled high
    task automatic bus(input logic w, input logic [VIC_AW-1:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= 4'hF;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (n >= 50) chk("ack", 32'h1, 32'h0);
        r = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    task automatic wr(input logic [VIC_AW-1:0] a, input logic [31:0] d);
        logic [31:0] dummy;
        bus(1'b1, a, d, dummy);
    endtask

    task automatic rd(input string name, input logic [VIC_AW-1:0] a, input logic [31:0] exp);
        logic [31:0] r;
        bus(1'b0, a, 32'h0000_0000, r);
        chk(name, exp, r);
    endtask

    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        rd("pend_rst", VIC_OFF_PEND, 32'h0000_0000);
        rd("mask_rst", VIC_OFF_MASK, 32'h0000_0000);
        rd("core_rst", VIC_OFF_CORE, 32'h0000_0000);
        rd("spur_rst", VIC_OFF_SPUR, 32'h0000_0000);
        rd("dbg_rst", VIC_OFF_DBG, 32'h0000_0000);
        wr(VIC_OFF_ENA, 32'h0000_0025);
        rd("mask_ena", VIC_OFF_MASK, 32'h0000_0025);
        wr(VIC_OFF_ENA, 32'h0000_0000);
        rd("mask_ena0", VIC_OFF_MASK, 32'h0000_0025);
        wr(VIC_OFF_DIS, 32'h0000_0004);
        rd("mask_dis", VIC_OFF_MASK, 32'h0000_0021);
        rd("ena_read", VIC_OFF_ENA, 32'h0000_0000);
        wr(VIC_OFF_SET, 32'h0000_0022);
        rd("pend_set", VIC_OFF_PEND, 32'h0000_0022);
        rd("core_norm", VIC_OFF_CORE, 32'h0000_0002);
        chk("norm_seen", 32'h1, {31'h0, norm_seen});
        // global mask holds both lines idle
        wr(VIC_OFF_DBG, 32'h0000_0002);
        rd("dbg_global_line_mask", VIC_OFF_DBG, 32'h0000_0002);
        rd("core_global_line_mask", VIC_OFF_CORE, 32'h0000_0000);
        chk("norm_line", 32'h1, {31'h0, norm_n});
        wr(VIC_OFF_DBG, 32'h0000_0001);
        rd("dbg_protection_enable", VIC_OFF_DBG, 32'h0000_0001);
        chk("protection_enable_on", 32'h1, {31'h0, protection_enable});
        // protection on: vector reads leave the pending source alone
        rd("ivec_protection_enable", VIC_OFF_IVEC, 32'h0000_0005);
        rd("pend_protection_enable", VIC_OFF_PEND, 32'h0000_0022);
        wr(VIC_OFF_DBG, 32'h0000_0000);
        chk("protection_enable_off", 32'h0, {31'h0, protection_enable});
        rd("core_ungm", VIC_OFF_CORE, 32'h0000_0002);
        // acknowledge, then end of service with arbitrary data
        rd("ivec_src", VIC_OFF_IVEC, 32'h0000_0005);
        rd("pend_ack", VIC_OFF_PEND, 32'h0000_0002);
        rd("core_svc", VIC_OFF_CORE, 32'h0000_0000);
        wr(VIC_OFF_SET, 32'h0000_0020);
        rd("core_busy", VIC_OFF_CORE, 32'h0000_0000);
        wr(VIC_OFF_EOS, 32'hA5C3_F00F);
        rd("core_eos", VIC_OFF_CORE, 32'h0000_0002);
        // protection on: a write to the vector place acknowledges
        wr(VIC_OFF_DBG, 32'h0000_0001);
        wr(VIC_OFF_IVEC, 32'h0000_0000);
        rd("pend_pwr", VIC_OFF_PEND, 32'h0000_0002);
        rd("core_pwr", VIC_OFF_CORE, 32'h0000_0000);
        wr(VIC_OFF_DBG, 32'h0000_0000);
        wr(VIC_OFF_EOS, 32'h0000_0000);
        wr(VIC_OFF_CLR, 32'h0000_0022);
        rd("pend_clr", VIC_OFF_PEND, 32'h0000_0000);
        rd("core_clr", VIC_OFF_CORE, 32'h0000_0000);
        wr(VIC_OFF_SPUR, 32'hCAFE_1234);
        rd("spur_rw", VIC_OFF_SPUR, 32'hCAFE_1234);
        rd("ivec_spur", VIC_OFF_IVEC, 32'hCAFE_1234);
        rd("fvec_spur", VIC_OFF_FVEC, 32'hCAFE_1234);
        wr(VIC_OFF_SET, 32'h0000_0001);
        rd("core_fast", VIC_OFF_CORE, 32'h0000_0001);
        chk("fast_seen", 32'h1, {31'h0, fast_seen});
        rd("fvec_fast", VIC_OFF_FVEC, VIC_FAST_VEC_DEFAULT);
        rd("pend_fack", VIC_OFF_PEND, 32'h0000_0000);
        rd("core_fidle", VIC_OFF_CORE, 32'h0000_0000);
        // source pin edge, then unmapped place
        @(posedge clk_i);
        src <= 32'h0000_0080;
        repeat (6) @(posedge clk_i);
        rd("pend_pin", VIC_OFF_PEND, 32'h0000_0080);
        wr(8'h3C, 32'hFFFF_FFFF);
        rd("unmapped", 8'h3C, 32'h0000_0000);
        rd("mask_end", VIC_OFF_MASK, 32'h0000_0021);
        // reset in mid-run clears the stores
        @(posedge clk_i);
        rst_i <= 1'b1;
        src <= 32'h0000_0000;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rd("spur_rst2", VIC_OFF_SPUR, 32'h0000_0000);
        rd("mask_rst2", VIC_OFF_MASK, 32'h0000_0000);
        rd("pend_rst2", VIC_OFF_PEND, 32'h0000_0000);
        results();
    end
endmodule // testbench
`default_nettype wire
